// >>> include/owlr_pkg.sv
// Package for the one-wire level command receiver: timing and field layout.
// Assumes a 25 MHz system clock; all times are converted to clock cycles.
package owlr_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ            = 25;
  localparam int START_TIME_NS      = 2000;
  localparam int END_OF_STREAM_NS   = 2000;
  localparam int ACK_LOW_TIME_US    = 512;
  localparam int ACK_VALID_DELAY_NS = 2000;
  // Least times round up, longest times round down
  localparam int START_CYC   = (START_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int EOS_CYC     = (END_OF_STREAM_NS * CLK_MHZ + 999) / 1000;
  localparam int ACK_VAL_CYC = (ACK_VALID_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int ACK_LOW_CYC = ACK_LOW_TIME_US * CLK_MHZ;

  // ------------------------------------------------------------------
  // Widths, field positions, reset values
  // ------------------------------------------------------------------
  localparam int CNT_W          = 16;
  localparam int BYTE_W         = 8;
  localparam int BITS_PER_BYTE  = 8;
  localparam int ACK_REQ_POS    = 7;
  localparam int SUB_ADDR_HI    = 6;
  localparam int SUB_ADDR_LO    = 5;
  localparam int LEVEL_HI       = 4;
  localparam int LEVEL_LO       = 0;
  localparam logic [7:0] DEV_ADDR_DEFAULT = 8'h72;
  localparam logic [4:0] LEVEL_RESET      = 5'h1F;
  localparam logic [1:0] SUB_ADDR_RESET   = 2'h0;

  // ------------------------------------------------------------------
  // Receiver states
  // ------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_LOW   = 6'b000010,
    ST_HIGH  = 6'b000100,
    ST_VALID = 6'b001000,
    ST_ACK   = 6'b010000,
    ST_WAIT  = 6'b100000
  } owlr_state_t;

endpackage : owlr_pkg

// >>> hdl/owlr_bit_decode.sv
// Bit decoder: turns low/high durations of one bit period into a bit.
// Assumes counts measured on the same clock as the receiver.
`timescale 1ns/1ps
module owlr_bit_decode (
  // Measured durations
  input  wire logic [owlr_pkg::CNT_W-1:0] low_cnt_i,
  input  wire logic [owlr_pkg::CNT_W-1:0] high_cnt_i,
  // Decision
  output logic                            bit_o,
  output logic                            bit_ok_o
);

  // ------------------------------------------------------------------
  // Ratio test
  // ------------------------------------------------------------------
  wire logic [owlr_pkg::CNT_W:0] low_x2  = {low_cnt_i, 1'b0};
  wire logic [owlr_pkg::CNT_W:0] high_x2 = {high_cnt_i, 1'b0};
  wire logic is_one  = ({1'b0, high_cnt_i} >= low_x2);
  wire logic is_zero = ({1'b0, low_cnt_i} >= high_x2);

  assign bit_o    = is_one;
  assign bit_ok_o = is_one ^ is_zero;

endmodule : owlr_bit_decode

// >>> hdl/owlr_receiver.sv
// One-wire level command receiver: address byte, data byte, acknowledge.
// Assumes the control line input is already synchronous to clk_i and that
// the line idles high through an external pullup.
`timescale 1ns/1ps
module owlr_receiver #(
  parameter int ACK_LOW_CYCLES = owlr_pkg::ACK_LOW_CYC
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // Control line, open drain
  input  wire logic       ctrl_i,
  output logic            ctrl_o,
  output logic            ctrl_oe_o,
  // Configuration
  input  wire logic [7:0] dev_addr_i,
  // Received command
  output logic [4:0]      level_code_o,
  output logic [1:0]      sub_addr_o,
  output logic            ack_request_bit_o,
  output logic            cmd_valid_o,
  output logic            frame_error_o
);

  // ------------------------------------------------------------------
  // State and datapath registers
  // ------------------------------------------------------------------
  owlr_pkg::owlr_state_t state_r, state_nxt;
  logic [owlr_pkg::CNT_W-1:0] low_cnt_r;
  logic [owlr_pkg::CNT_W-1:0] high_cnt_r;
  logic [owlr_pkg::CNT_W-1:0] tmr_r;
  logic [7:0]                 shift_r;
  logic [3:0]                 nbits_r;
  logic                       byte_idx_r;
  logic                       addr_ok_r;
  logic                       bit_err_r;
  logic                       ctrl_d_r;
  logic [4:0]                 level_r;
  logic [1:0]                 sub_r;
  logic                       req_r;
  logic                       valid_r;
  logic                       err_r;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  wire logic fall = ctrl_d_r & ~ctrl_i;
  wire logic dec_bit;
  wire logic dec_ok;

  owlr_bit_decode u_dec (
    .low_cnt_i  (low_cnt_r),
    .high_cnt_i (high_cnt_r),
    .bit_o      (dec_bit),
    .bit_ok_o   (dec_ok)
  );

  wire logic [7:0] shift_in = {shift_r[6:0], dec_bit};
  // End of stream: the line rests low after the closing fall of a byte
  wire logic eos_low  = (state_r == owlr_pkg::ST_LOW) && !ctrl_i &&
                        (low_cnt_r >=
                         owlr_pkg::CNT_W'(owlr_pkg::EOS_CYC - 1));
  // A long high inside a byte ends it as a cut byte
  wire logic eos_high = (state_r == owlr_pkg::ST_HIGH) && ctrl_i &&
                        (high_cnt_r >=
                         owlr_pkg::CNT_W'(owlr_pkg::EOS_CYC - 1));
  wire logic eos       = eos_low || eos_high;
  wire logic byte_full = (nbits_r == 4'(owlr_pkg::BITS_PER_BYTE));
  wire logic addr_now  = (shift_r == dev_addr_i);
  wire logic last_ok   = eos_low && byte_full && !bit_err_r;
  wire logic ack_go    = last_ok && byte_idx_r && addr_ok_r &&
                         shift_r[owlr_pkg::ACK_REQ_POS];
  wire logic tmr_done_val = (tmr_r >= owlr_pkg::CNT_W'(
                              owlr_pkg::ACK_VAL_CYC - 1));
  wire logic tmr_done_ack = (tmr_r >= owlr_pkg::CNT_W'(ACK_LOW_CYCLES - 1));
  wire logic cnt_max_l = &low_cnt_r;
  wire logic cnt_max_h = &high_cnt_r;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      owlr_pkg::ST_IDLE: begin
        if (fall) begin
          state_nxt = owlr_pkg::ST_LOW;
        end
      end
      owlr_pkg::ST_LOW: begin
        if (ctrl_i) begin
          state_nxt = owlr_pkg::ST_HIGH;
        end else if (eos) begin
          if (ack_go) begin
            state_nxt = owlr_pkg::ST_VALID;
          end else begin
            state_nxt = owlr_pkg::ST_IDLE;
          end
        end
      end
      owlr_pkg::ST_HIGH: begin
        if (fall) begin
          state_nxt = owlr_pkg::ST_LOW;
        end else if (eos) begin
          state_nxt = owlr_pkg::ST_IDLE;
        end
      end
      owlr_pkg::ST_VALID: begin
        if (tmr_done_val) begin
          state_nxt = owlr_pkg::ST_ACK;
        end
      end
      owlr_pkg::ST_ACK: begin
        if (tmr_done_ack) begin
          state_nxt = owlr_pkg::ST_WAIT;
        end
      end
      owlr_pkg::ST_WAIT: begin
        if (ctrl_i) begin
          state_nxt = owlr_pkg::ST_IDLE;
        end
      end
      default: state_nxt = owlr_pkg::ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------------
  // Line sampling and duration counters
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_d_r   <= 1'b1;
      state_r    <= owlr_pkg::ST_IDLE;
      low_cnt_r  <= '0;
      high_cnt_r <= '0;
      tmr_r      <= '0;
    end else begin
      ctrl_d_r <= ctrl_i;
      state_r  <= state_nxt;
      if (fall) begin
        // The falling sample is the first low sample of the period
        low_cnt_r  <= owlr_pkg::CNT_W'(1);
        high_cnt_r <= '0;
      end else if (!ctrl_i && !cnt_max_l) begin
        low_cnt_r <= low_cnt_r + 1'b1;
      end else if (ctrl_i && !cnt_max_h) begin
        high_cnt_r <= high_cnt_r + 1'b1;
      end
      if (state_nxt != state_r) begin
        tmr_r <= '0;
      end else begin
        tmr_r <= tmr_r + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Bit assembly; a falling edge in HIGH closes one bit
  // ------------------------------------------------------------------
  wire logic bit_end = (state_r == owlr_pkg::ST_HIGH) && fall;
  wire logic byte_end = eos;
  wire logic start_new = (state_r == owlr_pkg::ST_IDLE) && fall;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_r    <= '0;
      nbits_r    <= '0;
      byte_idx_r <= 1'b0;
      addr_ok_r  <= 1'b0;
      bit_err_r  <= 1'b0;
    end else if (start_new && !byte_idx_r) begin
      nbits_r   <= '0;
      bit_err_r <= 1'b0;
    end else if (bit_end) begin
      shift_r   <= shift_in;
      nbits_r   <= nbits_r + 1'b1;
      bit_err_r <= bit_err_r | ~dec_ok | byte_full;
    end else if (byte_end) begin
      nbits_r   <= '0;
      if (last_ok && !byte_idx_r) begin
        byte_idx_r <= 1'b1;
        addr_ok_r  <= addr_now;
      end else begin
        byte_idx_r <= 1'b0;
        addr_ok_r  <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Command outputs
  // ------------------------------------------------------------------
  wire logic data_done = byte_end && byte_idx_r && last_ok;
  wire logic bad_end   = byte_end && !last_ok;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      level_r <= owlr_pkg::LEVEL_RESET;
      sub_r   <= owlr_pkg::SUB_ADDR_RESET;
      req_r   <= 1'b0;
      valid_r <= 1'b0;
      err_r   <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      err_r   <= bad_end;
      if (data_done && addr_ok_r) begin
        level_r <= shift_r[owlr_pkg::LEVEL_HI:owlr_pkg::LEVEL_LO];
        sub_r   <= shift_r[owlr_pkg::SUB_ADDR_HI:owlr_pkg::SUB_ADDR_LO];
        req_r   <= shift_r[owlr_pkg::ACK_REQ_POS];
        valid_r <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Open-drain acknowledge
  // ------------------------------------------------------------------
  assign ctrl_o            = 1'b0;
  assign ctrl_oe_o         = (state_r == owlr_pkg::ST_ACK);
  assign level_code_o      = level_r;
  assign sub_addr_o        = sub_r;
  assign ack_request_bit_o = req_r;
  assign cmd_valid_o       = valid_r;
  assign frame_error_o     = err_r;

endmodule : owlr_receiver

// >>> sim/owlr_receiver_props.sv
// Checker for the receiver: acknowledge timing and result pulses.
// Assumes binding to owlr_receiver; sees its ports only.
`timescale 1ns/1ps
module owlr_receiver_chk #(
  parameter int ACK_LOW_CYCLES = owlr_pkg::ACK_LOW_CYC
) (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  // Control line drive
  input wire logic       ctrl_o,
  input wire logic       ctrl_oe_o,
  // Results
  input wire logic [4:0] level_code_o,
  input wire logic [1:0] sub_addr_o,
  input wire logic       ack_request_bit_o,
  input wire logic       cmd_valid_o,
  input wire logic       frame_error_o
);
  // ------------------------------------------------------------
  // Pulldown length counter
  // ------------------------------------------------------------
  logic [15:0] oe_cnt_r;
  logic [15:0] oe_cnt_nxt;
  assign oe_cnt_nxt = ctrl_oe_o ? oe_cnt_r + 16'h1 : 16'h0;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) oe_cnt_r <= 16'h0;
    else oe_cnt_r <= oe_cnt_nxt;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ack_max_a: assert property (oe_cnt_r <= 16'(ACK_LOW_CYCLES))
    else $error("pulldown held too long");
  ack_len_a: assert property ($fell(ctrl_oe_o) |->
    oe_cnt_r == 16'(ACK_LOW_CYCLES)) else $error("pulldown length wrong");
  od_low_a: assert property (ctrl_oe_o |-> !ctrl_o)
    else $error("line driven high");
  ack_req_a: assert property ($rose(ctrl_oe_o) |-> ack_request_bit_o)
    else $error("pulldown without request");
  ack_delay_a: assert property (cmd_valid_o ##1 ack_request_bit_o
    |-> ##[38:60] $rose(ctrl_oe_o)) else $error("no pulldown after delay");
  valid_pulse_a: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("valid pulse too long");
  err_pulse_a: assert property (frame_error_o |=> !frame_error_o)
    else $error("error pulse too long");
  one_result_a: assert property (!(cmd_valid_o && frame_error_o))
    else $error("valid and error together");
  hold_fields_a: assert property (!cmd_valid_o && !$past(cmd_valid_o)
    |-> $stable(level_code_o) && $stable(sub_addr_o))
    else $error("fields changed without command");
  cover property ($rose(ctrl_oe_o));
  cover property (cmd_valid_o);
  cover property (frame_error_o);
endmodule : owlr_receiver_chk

bind owlr_receiver owlr_receiver_chk #(.ACK_LOW_CYCLES(ACK_LOW_CYCLES)) u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .ctrl_o(ctrl_o),
  .ctrl_oe_o(ctrl_oe_o), .level_code_o(level_code_o),
  .sub_addr_o(sub_addr_o), .ack_request_bit_o(ack_request_bit_o),
  .cmd_valid_o(cmd_valid_o), .frame_error_o(frame_error_o));

// >>> sim/owlr_host_model.sv
// Host model: open-drain driver of the control line with pullup.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
module owlr_host_model (
  // Clock
  input  wire logic clk_i,
  // Device pulldown
  input  wire logic pull_dn_i,
  // Resolved line level
  output logic      line_o
);
  logic drv_low_r = 1'b0;
  logic ack_seen  = 1'b0;
  assign line_o = ~(drv_low_r | pull_dn_i);
  task hold(input logic lvl, input int n);
    drv_low_r <= ~lvl;
    repeat (n) @(posedge clk_i);
  endtask : hold
  task start();
    hold(1'b1, 60);
  endtask : start
  task send_byte(input logic [7:0] v, input int nb, input logic bad);
    for (int i = 7; i > 7 - nb; i--) begin
      hold(1'b0, bad ? 6 : (v[i] ? 4 : 8));
      hold(1'b1, bad ? 6 : (v[i] ? 8 : 4));
    end
    hold(1'b0, owlr_pkg::EOS_CYC + 10);
  endtask : send_byte
  task wait_ack();
    ack_seen = 1'b0;
    hold(1'b0, owlr_pkg::ACK_VAL_CYC);
    drv_low_r <= 1'b0;
    repeat (200) begin
      @(posedge clk_i);
      if (line_o === 1'b0) ack_seen = 1'b1;
    end
  endtask : wait_ack
endmodule : owlr_host_model

// >>> sim/test_owlr_receiver.sv
// Testbench for owlr_receiver: host frames with expected results.
// Assumes owlr_host_model and the bound checker are compiled first.
`timescale 1ns/1ps
module test_owlr_receiver;
  localparam int ACK_CYC = 64;
  logic       clk_i      = 1'b0;
  logic       reset_n_i  = 1'b0;
  logic [7:0] dev_addr_i = 8'h72;
  logic       ctrl_i;
  logic       ctrl_o, ctrl_oe_o, ack_request_bit_o;
  logic       cmd_valid_o, frame_error_o;
  logic [4:0] level_code_o;
  logic [1:0] sub_addr_o;
  int n_fail = 0, samples_checked = 0, cyc = 0;
  int n_valid = 0, n_err = 0, n_oe = 0, dv, de, dk;
  always #20 clk_i = ~clk_i;
  owlr_receiver #(.ACK_LOW_CYCLES(ACK_CYC)) uut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ctrl_i(ctrl_i),
    .ctrl_o(ctrl_o), .ctrl_oe_o(ctrl_oe_o), .dev_addr_i(dev_addr_i),
    .level_code_o(level_code_o), .sub_addr_o(sub_addr_o),
    .ack_request_bit_o(ack_request_bit_o), .cmd_valid_o(cmd_valid_o),
    .frame_error_o(frame_error_o));
  owlr_host_model host (.clk_i(clk_i), .pull_dn_i(ctrl_oe_o),
    .line_o(ctrl_i));
  always @(posedge clk_i) begin
    cyc++;
    if (cmd_valid_o === 1'b1) n_valid++;
    if (frame_error_o === 1'b1) n_err++;
    if (ctrl_oe_o === 1'b1) n_oe++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task run(input logic [7:0] a, input logic [7:0] d, input int nb,
           input logic bad);
    int v0, e0, k0;
    v0 = n_valid;
    e0 = n_err;
    k0 = n_oe;
    host.send_byte(a, 8, 1'b0);
    host.start();
    host.send_byte(d, nb, bad);
    host.wait_ack();
    dv = n_valid - v0;
    de = n_err - e0;
    dk = n_oe - k0;
  endtask : run
  task test_done();
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    chk(16'(level_code_o), 16'h1F);
    chk(16'(sub_addr_o), 16'h0);
    run(8'h72, 8'h55, 8, 1'b0);
    chk(16'(dv), 16'h1);
    chk(16'(level_code_o), 16'h15);
    chk(16'(sub_addr_o), 16'h2);
    chk(16'(ack_request_bit_o), 16'h0);
    chk(16'(de), 16'h0);
    chk(16'(dk), 16'h0);
    run(8'h72, 8'hE3, 8, 1'b0);
    chk(16'(dv), 16'h1);
    chk(16'(dk), 16'(ACK_CYC));
    chk(16'(host.ack_seen), 16'h1);
    chk(16'(level_code_o), 16'h03);
    chk(16'(sub_addr_o), 16'h3);
    chk(16'(ack_request_bit_o), 16'h1);
    run(8'h4E, 8'h80, 8, 1'b0);
    chk(16'(dv), 16'h0);
    chk(16'(dk), 16'h0);
    run(8'h72, 8'h9F, 5, 1'b0);
    chk(16'(dv), 16'h0);
    chk(16'(de), 16'h1);
    run(8'h72, 8'h9F, 8, 1'b1);
    chk(16'(dv + dk), 16'h0);
    chk(16'(level_code_o), 16'h03);
    test_done();
  end
endmodule : test_owlr_receiver
